// ---- src/plc_pkg.sv ----
// Shared constants and types for the looping controller and its one-bit processor
package plc_pkg;
    // ==========================================================
    // Instruction codes of the one-bit processor
    typedef enum logic [3:0] {
        OP_FLAG_ZERO_NO_OP = 4'h0,
        OP_LOAD_RESULT = 4'h1,
        OP_LOAD_COMPLEMENT = 4'h2,
        OP_AND = 4'h3,
        OP_AND_COMPLEMENT = 4'h4,
        OP_OR = 4'h5,
        OP_OR_COMPLEMENT = 4'h6,
        OP_XNOR = 4'h7,
        OP_STORE_RESULT = 4'h8,
        OP_STORE_RESULT_COMPLEMENT = 4'h9,
        OP_INPUT_ENABLE = 4'ha,
        OP_OUTPUT_ENABLE = 4'hb,
        OP_JUMP_PULSE = 4'hc,
        OP_RETURN_PULSE = 4'hd,
        OP_SKIP_IF_ZERO = 4'he,
        OP_FLAG_F_NO_OP = 4'hf
    } plc_op_t;

    // ==========================================================
    // Widths and reset values
    localparam int PLC_WORD_W = 4;
    localparam int PLC_PC_W_DEF = 7;
    localparam logic PLC_PHASE_RST = 1'b1;
    localparam logic PLC_HALTED_RST = 1'b1;
    localparam logic [3:0] PLC_WORD_RST = 4'h0;
    localparam logic [15:0] PLC_LATCH_RST = 16'h0000;
    localparam logic [3:0] PLC_RESULT_FEEDBACK_ADDR = 4'h0;

    // ==========================================================
    // Register map, byte offsets on the AXI4-Lite bus
    localparam logic [7:0] PLC_REG_CTRL = 8'h00;
    localparam logic [7:0] PLC_REG_PRESET = 8'h04;
    localparam logic [7:0] PLC_REG_MEM = 8'h08;
    localparam logic [7:0] PLC_REG_STATUS = 8'h0c;
    localparam logic [7:0] PLC_REG_OUTS = 8'h10;
    localparam int PLC_CTRL_RUN_BIT = 0;
    localparam int PLC_CTRL_HALT_BIT = 1;
    localparam int PLC_MEM_ADDR_LSB = 8;
    localparam int PLC_STATUS_RR_BIT = 16;
    localparam int PLC_STATUS_HALTED_BIT = 17;
    localparam int PLC_STATUS_PHASE_BIT = 18;
    localparam logic [1:0] PLC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PLC_RESP_SLVERR = 2'h2;
endpackage : plc_pkg

// ---- src/plc_link_if.sv ----
// Link between the controller system logic and the one-bit processor
`timescale 1ns/1ps
interface plc_link_if;
    // ==========================================================
    // Link signals
    logic clk_phase;
    logic icu_reset;
    logic [3:0] mem_word;
    logic sys_data_o;
    logic sys_data_oe_n;
    logic icu_data_o;
    logic icu_data_oe_n;
    logic write_strobe;
    logic flag_f_pulse;
    logic result_bit_reg;
    logic data_line;

    // Bidirectional data line with a weak pull-up
    assign data_line = !icu_data_oe_n ? icu_data_o : (!sys_data_oe_n ? sys_data_o : 1'b1);

    modport icu (
        input clk_phase, icu_reset, mem_word, data_line,
        output icu_data_o, icu_data_oe_n, write_strobe, flag_f_pulse, result_bit_reg
    );
    modport sys (
        input data_line, write_strobe, flag_f_pulse, result_bit_reg,
        output clk_phase, icu_reset, mem_word, sys_data_o, sys_data_oe_n
    );
endinterface : plc_link_if

// ---- src/plc_icu.sv ----
// One-bit processor end: fetch on clock high, execute on clock low
`timescale 1ns/1ps
module plc_icu
    import plc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    plc_link_if.icu link,
    output logic input_enable_view,
    output logic output_enable_view
);
    // ==========================================================
    // State
    typedef struct packed {
        plc_op_t ir;
        logic rr;
        logic ien;
        logic output_enable_reg;
        logic skip;
        logic data_o;
        logic data_oe_n;
        logic wr;
        logic flag;
    } plc_icu_st_t;

    plc_icu_st_t st;
    plc_icu_st_t next_st;
    logic fetched_store;
    logic operand;

    // ==========================================================
    // Next state
    always_comb
    begin
        next_st = st;
        fetched_store = 1'b0;
        operand = link.data_line & st.ien;
        if (link.clk_phase)
        begin
            // Opcode taken on the falling clock edge; a skipped one becomes no-op
            next_st.ir = st.skip ? OP_FLAG_ZERO_NO_OP : plc_op_t'(link.mem_word);
            next_st.skip = 1'b0;
            fetched_store = !st.skip && (link.mem_word == OP_STORE_RESULT
                || link.mem_word == OP_STORE_RESULT_COMPLEMENT);
            next_st.data_oe_n = !fetched_store;
            next_st.data_o = (link.mem_word == OP_STORE_RESULT_COMPLEMENT) ? ~st.rr : st.rr;
            next_st.wr = fetched_store && st.output_enable_reg;
            next_st.flag = !st.skip && (link.mem_word == OP_FLAG_F_NO_OP);
        end
        else
        begin
            // Execute ends on the rising edge; strobes last one low phase
            next_st.data_oe_n = 1'b1;
            next_st.wr = 1'b0;
            next_st.flag = 1'b0;
            unique case (st.ir)
                OP_LOAD_RESULT: next_st.rr = operand;
                OP_LOAD_COMPLEMENT: next_st.rr = ~operand;
                OP_AND: next_st.rr = st.rr & operand;
                OP_AND_COMPLEMENT: next_st.rr = st.rr & ~operand;
                OP_OR: next_st.rr = st.rr | operand;
                OP_OR_COMPLEMENT: next_st.rr = st.rr | ~operand;
                OP_XNOR: next_st.rr = st.rr ~^ operand;
                OP_INPUT_ENABLE: next_st.ien = link.data_line;
                OP_OUTPUT_ENABLE: next_st.output_enable_reg = link.data_line;
                OP_SKIP_IF_ZERO: next_st.skip = !st.rr;
                // All-zeros and all-ones codes leave logic state alone
                OP_FLAG_ZERO_NO_OP, OP_FLAG_F_NO_OP: next_st.rr = st.rr;
                OP_STORE_RESULT, OP_STORE_RESULT_COMPLEMENT,
                OP_JUMP_PULSE, OP_RETURN_PULSE: next_st.rr = st.rr;
            endcase
        end
        // Held reset from the halt latch clears the processor
        if (link.icu_reset)
        begin
            next_st = '{ir: OP_FLAG_ZERO_NO_OP, data_oe_n: 1'b1, default: 1'b0};
        end
    end

    // ==========================================================
    // Register
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '{ir: OP_FLAG_ZERO_NO_OP, data_oe_n: 1'b1, default: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from state
    assign link.icu_data_o = st.data_o;
    assign link.icu_data_oe_n = st.data_oe_n;
    assign link.write_strobe = st.wr;
    assign link.flag_f_pulse = st.flag;
    assign link.result_bit_reg = st.rr;
    assign input_enable_view = st.ien;
    assign output_enable_view = st.output_enable_reg;
endmodule : plc_icu

// ---- src/plc_system.sv ----
// Controller system end: counter, interlaced memory, input selector, output latches
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module plc_system
    import plc_pkg::*;
#(
    parameter int PC_W = PLC_PC_W_DEF
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    plc_link_if.sys link,
    input wire logic [7:0] x_in,
    output logic [7:0] out_pins,
    output logic [7:0] scratch_pins,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ==========================================================
    // Elaboration check
    // Operand field fixed at one 4-bit word; wider needs 8-bit words
    if (PC_W < 1 || PC_W > 8)
    begin : g_bad_pc_w
        $error("PC_W must lie between 1 and 8");
    end

    localparam int MEM_DEPTH = 2 ** (PC_W + 1);

    // ==========================================================
    // State
    typedef struct packed {
        logic phase;
        logic halted;
        logic [PC_W-1:0] pc;
        logic [PC_W-1:0] preset;
        logic [3:0] word;
        logic [3:0] operand;
        logic [15:0] latch;
        logic data_o;
        logic data_oe_n;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } plc_sys_st_t;
    // Value after reset: halted, fetch phase, every ready up
    localparam plc_sys_st_t SYS_RST = '{phase: PLC_PHASE_RST, halted: PLC_HALTED_RST,
        word: PLC_WORD_RST, data_oe_n: 1'b1, awready: 1'b1, wready: 1'b1, arready: 1'b1,
        default: '0};

    plc_sys_st_t st;
    plc_sys_st_t next_st;
    logic [3:0] mem [MEM_DEPTH];
    logic mem_we;
    logic [PC_W:0] mem_waddr;
    logic [3:0] mem_wdata;
    logic [3:0] opnd;
    logic sel_bit;
    logic is_store;

    // ==========================================================
    // Machine sequencing and I/O
    always_comb
    begin
        next_st = st;
        mem_we = 1'b0;
        mem_waddr = '0;
        mem_wdata = '0;
        // Operand word is the odd location of the statement
        opnd = mem[{st.pc, 1'b1}];
        is_store = st.word == OP_STORE_RESULT || st.word == OP_STORE_RESULT_COMPLEMENT;
        // Address zero returns the result bit, no external input there
        sel_bit = opnd[3] ? st.latch[opnd] : x_in[opnd[2:0]];
        if (opnd == PLC_RESULT_FEEDBACK_ADDR)
        begin
            sel_bit = link.result_bit_reg;
        end

        next_st.phase = ~st.phase;
        if (st.phase)
        begin
            // Falling clock edge: selector drives unless a store follows
            next_st.operand = opnd;
            next_st.data_oe_n = is_store;
            next_st.data_o = sel_bit;
        end
        else
        begin
            // Rising clock edge: capture store data, advance counter
            next_st.data_oe_n = 1'b1;
            if (link.write_strobe)
            begin
                next_st.latch[st.operand] = link.data_line;
            end
            if (st.halted)
            begin
                next_st.pc = '0;
            end
            else if (link.flag_f_pulse)
            begin
                next_st.pc = st.preset;
            end
            else
            begin
                next_st.pc = PC_W'(st.pc + 1'b1);
            end
        end

        // ------------------------------------------------------
        // AXI4-Lite write channel
        if (s_axi_awvalid && st.awready)
        begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready)
        begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        next_st.bvalid = st.bvalid && !s_axi_bready;
        if (st.aw_got && st.w_got && !st.bvalid)
        begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = PLC_RESP_OKAY;
            unique case (st.awaddr)
                PLC_REG_CTRL:
                begin
                    // Momentary run and halt; halt wins if both
                    if (st.wstrb[0] && |st.wdata[PLC_CTRL_HALT_BIT:PLC_CTRL_RUN_BIT])
                    begin
                        next_st.halted = st.wdata[PLC_CTRL_HALT_BIT];
                    end
                end
                PLC_REG_PRESET: next_st.preset = st.wstrb[0] ? st.wdata[PC_W-1:0] : st.preset;
                PLC_REG_MEM:
                begin
                    mem_we = &st.wstrb[1:0];
                    mem_waddr = st.wdata[PLC_MEM_ADDR_LSB +: PC_W + 1];
                    mem_wdata = st.wdata[3:0];
                end
                PLC_REG_STATUS, PLC_REG_OUTS: next_st.bresp = PLC_RESP_OKAY;
                default: next_st.bresp = PLC_RESP_SLVERR;
            endcase
        end
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready = !next_st.w_got && !next_st.bvalid;

        // ------------------------------------------------------
        // AXI4-Lite read channel
        next_st.rvalid = st.rvalid && !s_axi_rready;
        if (s_axi_arvalid && st.arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = PLC_RESP_OKAY;
            next_st.rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                PLC_REG_CTRL: next_st.rdata[PLC_CTRL_HALT_BIT] = st.halted;
                PLC_REG_PRESET: next_st.rdata[PC_W-1:0] = st.preset;
                PLC_REG_MEM: next_st.rdata[PC_W-1:0] = st.pc;
                PLC_REG_STATUS:
                begin
                    next_st.rdata[PC_W-1:0] = st.pc;
                    next_st.rdata[PLC_STATUS_RR_BIT] = link.result_bit_reg;
                    next_st.rdata[PLC_STATUS_HALTED_BIT] = st.halted;
                    next_st.rdata[PLC_STATUS_PHASE_BIT] = st.phase;
                end
                PLC_REG_OUTS: next_st.rdata[15:0] = st.latch;
                default: next_st.rresp = PLC_RESP_SLVERR;
            endcase
        end
        next_st.arready = !next_st.rvalid;

        // Halted system keeps every output latch at zero
        if (st.halted)
        begin
            next_st.latch = PLC_LATCH_RST;
        end
        // Inverted clock level is the lowest memory address bit: high reads opcode
        next_st.word = mem[{next_st.pc, ~next_st.phase}];
    end

    // ==========================================================
    // Register
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= SYS_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Program memory, written over the register bus
    always_ff @(posedge sys_clk)
    begin
        if (mem_we)
        begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    // ==========================================================
    // Outputs straight from state
    assign link.clk_phase = st.phase;
    assign link.icu_reset = st.halted;
    assign link.mem_word = st.word;
    assign link.sys_data_o = st.data_o;
    assign link.sys_data_oe_n = st.data_oe_n;
    assign out_pins = st.latch[7:0];
    assign scratch_pins = st.latch[15:8];
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
endmodule : plc_system

// ---- dv/plc_link_checker.sv ----
// Concurrent checks on the link between the controller system and the processor
`timescale 1ns/1ps
module plc_link_checker
    import plc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_phase,
    input wire logic icu_reset,
    input wire logic sys_data_oe_n,
    input wire logic icu_data_oe_n,
    input wire logic write_strobe,
    input wire logic flag_f_pulse,
    input wire logic result_bit_reg
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // ==========================================================
    // Machine cycle and strobes
    phase_toggle_a: assert property ($past(resetn) |-> clk_phase != $past(clk_phase))
        else $error("machine clock phase did not toggle");
    strobe_timing_a: assert property (write_strobe |-> !clk_phase && !icu_data_oe_n ##1 !write_strobe)
        else $error("write strobe outside a one-cycle store execute");
    flag_pulse_a: assert property (flag_f_pulse |-> !clk_phase ##1 !flag_f_pulse)
        else $error("flag pulse longer than one cycle or in fetch");
    store_drive_a: assert property (!icu_data_oe_n |-> !clk_phase)
        else $error("processor drives data line during fetch");

    // ==========================================================
    // Input selector drive
    sel_alone_a: assert property (!sys_data_oe_n |-> !clk_phase && icu_data_oe_n)
        else $error("selector drives in fetch or against a store");
    sel_drive_a: assert property (!clk_phase && icu_data_oe_n && !icu_reset && !$past(icu_reset)
        |-> !sys_data_oe_n)
        else $error("selector idle in a non-store execute phase");

    // ==========================================================
    // Halt keeps the processor quiet
    halt_no_strobe_a: assert property (icu_reset [*3] |-> !write_strobe)
        else $error("write strobe while halted");
    halt_rr_clear_a: assert property (icu_reset [*3] |-> !result_bit_reg)
        else $error("result bit set while halted");

    c_store: cover property (write_strobe);
    c_flag: cover property (flag_f_pulse);
    c_select: cover property (!sys_data_oe_n);
    c_run: cover property ($fell(icu_reset));
endmodule : plc_link_checker

// ---- dv/looping_plc_io_sequencer_bench.sv ----
// Self-checking bench joining controller system and processor over the link
`timescale 1ns/1ps
module looping_plc_io_sequencer_bench;
    import plc_pkg::*;
    localparam int PC_W = 4;
    logic sys_clk = 1'b0, resetn = 1'b0;
    logic [7:0] x_in = 8'h00, awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, r, r2, rd;
    logic [63:0] stmt;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, ie_view, oe_view, oen_on, skip;
    logic [1:0] bresp, rresp;
    logic [7:0] out_pins, scratch_pins, xv, eo, es;
    logic [3:0] prog [32];
    int n_errors = 0, checks = 0, cycles = 0, it, i, a, b, c, k, a2, a3, a4, a5;
    integer seed = 32'h47dcd92e;

    plc_link_if link_i ();
    plc_icu plc_icu_i (.sys_clk(sys_clk), .resetn(resetn), .link(link_i),
        .input_enable_view(ie_view), .output_enable_view(oe_view));
    plc_system #(.PC_W(PC_W)) plc_system_i (.sys_clk(sys_clk), .resetn(resetn), .link(link_i),
        .x_in(x_in), .out_pins(out_pins), .scratch_pins(scratch_pins),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    plc_link_checker plc_link_checker_i (.sys_clk(sys_clk), .resetn(resetn),
        .clk_phase(link_i.clk_phase), .icu_reset(link_i.icu_reset),
        .sys_data_oe_n(link_i.sys_data_oe_n), .icu_data_oe_n(link_i.icu_data_oe_n),
        .write_strobe(link_i.write_strobe), .flag_f_pulse(link_i.flag_f_pulse),
        .result_bit_reg(link_i.result_bit_reg));

    // ==========================================================
    // Clock, watchdog and verdict
    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end

    // Cuts a hang short
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            n_errors++;
            give_verdict();
        end
    end

    task give_verdict();
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // ==========================================================
    // Comparisons
    task cmp_word(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp_word

    task cmp_pins(input logic [7:0] g, input logic [7:0] e);
        cmp_word({24'h0, g}, {24'h0, e});
    endtask : cmp_pins

    task cmp_resp(input logic [1:0] g, input logic [1:0] e);
        cmp_word({30'h0, g}, {30'h0, e});
    endtask : cmp_resp

    // Expected result of load, skip if zero, xnor, or-not, and-not
    function automatic logic skip_block(input logic [7:0] x, input int p, q, s, t);
        logic v;
        v = x[p] & x[q];
        v = v | ~x[s];
        v = v & ~x[t];
        return v;
    endfunction : skip_block

    // ==========================================================
    // AXI4-Lite master: hold each channel until its ready
    task axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        cmp_resp(bresp, er);
    endtask : axi_wr

    task axi_rd(input logic [7:0] ad, output logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        d = rdata;
        cmp_resp(rresp, er);
    endtask : axi_rd

    // ==========================================================
    // Main sequence: random programs run, halted and checked
    initial
    begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        axi_rd(8'h20, rd, PLC_RESP_SLVERR);
        cmp_word(rd, 32'h0);
        axi_wr(8'h24, 32'h1, PLC_RESP_SLVERR);
        // Write with no byte strobes leaves the preset untouched
        wstrb <= 4'h0;
        axi_wr(PLC_REG_PRESET, 32'h5, PLC_RESP_OKAY);
        wstrb <= 4'hf;
        axi_rd(PLC_REG_PRESET, rd, PLC_RESP_OKAY);
        cmp_word(rd, 32'h0);
        axi_wr(PLC_REG_PRESET, 32'h0, PLC_RESP_OKAY);
        for (it = 0; it < 12; it++)
        begin
            axi_wr(PLC_REG_CTRL, 32'h2, PLC_RESP_OKAY);
            repeat (4) @(posedge sys_clk);
            cmp_pins(out_pins, 8'h00);
            cmp_pins(scratch_pins, 8'h00);
            axi_rd(PLC_REG_STATUS, rd, PLC_RESP_OKAY);
            cmp_word(rd & 32'h0003_000f, 32'h0002_0000);
            r = $random(seed);
            a = 1 + r[7:0] % 5;
            b = r[10:8];
            k = r[13:11];
            c = (b + 1 + r[18:16] % 7) % 8;
            r2 = $random(seed);
            a2 = 1 + r2[7:0] % 5;
            a3 = 1 + r2[15:8] % 5;
            a4 = 1 + r2[23:16] % 5;
            a5 = 1 + r2[31:24] % 5;
            oen_on = (it == 1) ? 1'b0 : (r[20] | r[22] | it == 0);
            skip = (it == 2) | (r[21] & r[23] & it != 0);
            xv = {2'b01, r[29:24]};
            x_in <= xv;
            // Unused statements are no-ops with random operands
            for (i = 0; i < 32; i++)
                prog[i] = i[0] ? 4'(r >> i) : OP_FLAG_ZERO_NO_OP;
            stmt = {OP_INPUT_ENABLE, 4'h6, OP_OUTPUT_ENABLE, oen_on ? 4'h6 : 4'h7,
                OP_LOAD_RESULT, 4'(a), OP_STORE_RESULT, 4'(b),
                skip ? OP_FLAG_F_NO_OP : OP_STORE_RESULT_COMPLEMENT, 4'(8 + k),
                OP_LOAD_RESULT, 4'(8 + k), OP_AND, PLC_RESULT_FEEDBACK_ADDR,
                OP_STORE_RESULT, 4'(c)};
            for (i = 0; i < 16; i++)
                prog[i] = stmt[63 - 4 * i -: 4];
            // Skip-if-zero block with a don't-care operand, stored to scratch
            stmt = {OP_LOAD_RESULT, 4'(a2), OP_SKIP_IF_ZERO, 4'(r2 >> 4), OP_XNOR, 4'(a3),
                OP_OR_COMPLEMENT, 4'(a4), OP_AND_COMPLEMENT, 4'(a5),
                OP_STORE_RESULT, 4'(8 + (k + 4) % 8), 16'h0000};
            for (i = 0; i < 12; i++)
                prog[16 + i] = stmt[63 - 4 * i -: 4];
            prog[30] = OP_FLAG_F_NO_OP;
            for (i = 0; i < 32; i++)
                axi_wr(PLC_REG_MEM, (32'(i) << PLC_MEM_ADDR_LSB) | 32'(prog[i]), PLC_RESP_OKAY);
            axi_wr(PLC_REG_CTRL, 32'h1, PLC_RESP_OKAY);
            repeat (200) @(posedge sys_clk);
            eo = 8'h00;
            es = 8'h00;
            if (oen_on)
            begin
                eo[b] = xv[a];
                if (!skip)
                begin
                    es[k] = ~xv[a];
                    eo[c] = ~xv[a];
                    es[(k + 4) % 8] = skip_block(xv, a2, a3, a4, a5);
                end
            end
            cmp_pins(out_pins, eo);
            cmp_pins(scratch_pins, es);
            cmp_pins({7'h0, oe_view}, {7'h0, oen_on});
            cmp_pins({7'h0, ie_view}, 8'h01);
        end
        give_verdict();
    end
endmodule : looping_plc_io_sequencer_bench
